// *** tb/msd_datapath_monitor.sv ***
// Purpose: port-level assertions for the multiply-subtract datapath
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every datapath instance
`timescale 1ns/1ns
module msd_datapath_monitor (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire msd_pkg::msd_req_s I_REQ,
  input wire msd_pkg::msd_res_s O_RES,
  input wire msd_pkg::msd_flags_s O_FLAGS,
  input wire logic [3:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  input wire logic [31:0] O_REG_RDATA
);
  logic en_q;
  logic clr_w;
  // mirror of flag enable, so gated updates are not judged
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      en_q <= 1'b1;
    end else if (I_REG_WR && I_REG_ADDR == msd_pkg::MSD_ADDR_CTRL) begin
      en_q <= I_REG_WDATA[msd_pkg::MSD_CTRL_FLAG_EN];
    end
  end
  assign clr_w = I_REG_WR && I_REG_ADDR == msd_pkg::MSD_ADDR_STAT;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  sequence s_u32;
    I_REQ.valid && I_REQ.op == msd_pkg::MSD_OP_U && !I_REQ.wide;
  endsequence
  a_res_one_cycle: assert property (I_REQ.valid && $onehot(I_REQ.op) |=> O_RES.valid)
    else $error("result valid missing after request");
  a_res_idle: assert property (!(I_REQ.valid && $onehot(I_REQ.op)) |=> !O_RES.valid)
    else $error("result valid without request");
  a_u32_wrap: assert property (s_u32 ##0 (!I_REQ.sat && !I_REQ.use_imm) |=>
    O_RES.value == {32'h0, $past(I_REQ.acc[31:0] - I_REQ.opa * I_REQ.opb)}) else $error("unsigned result wrong");
  a_imm_zext: assert property (s_u32 ##0 (!I_REQ.sat && I_REQ.use_imm) |=>
    O_RES.value[31:0] == $past(I_REQ.acc[31:0] - I_REQ.opa * {23'h0, I_REQ.nine_bit_immediate}))
    else $error("immediate not zero extended");
  a_usat_floor: assert property (s_u32 ##0 (I_REQ.sat && !I_REQ.use_imm &&
    {32'h0, I_REQ.acc[31:0]} < 64'(I_REQ.opa) * I_REQ.opb) |=> O_RES.value == 64'h0)
    else $error("unsigned underflow not clamped");
  a_q_maxpos: assert property (I_REQ.valid && I_REQ.op == msd_pkg::MSD_OP_Q &&
    I_REQ.qsel == msd_pkg::MSD_Q_UU && I_REQ.shift1 && !I_REQ.sat && !I_REQ.wide &&
    I_REQ.opa[31:16] == 16'h8000 && I_REQ.opb[31:16] == 16'h8000 |=>
    O_RES.value[31:0] == $past(I_REQ.acc[31:0]) - 32'h7fff_ffff) else $error("most negative square wrong");
  a_sticky_keep: assert property (O_FLAGS.sticky_ovf_flag && !(clr_w && I_REG_WDATA[1]) |=>
    O_FLAGS.sticky_ovf_flag) else $error("sticky overflow lost");
  a_adv_sticky_keep: assert property (O_FLAGS.sticky_adv_ovf_flag && !(clr_w && I_REG_WDATA[3]) |=>
    O_FLAGS.sticky_adv_ovf_flag) else $error("sticky advanced overflow lost");
  a_ovf_to_sticky: assert property ($rose(O_FLAGS.ovf) |-> O_FLAGS.sticky_ovf_flag)
    else $error("overflow without sticky");
  a_adv_final: assert property (s_u32 ##0 en_q |=>
    O_FLAGS.adv_ovf_flag == (O_RES.value[31] ^ O_RES.value[30])) else $error("advanced overflow wrong");
  a_rd_idle: assert property (!I_REG_RD |=> O_REG_RDATA == 32'h0)
    else $error("read data outside read cycle");
endmodule : msd_datapath_monitor

bind msd_datapath msd_datapath_monitor u_mon (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REQ(I_REQ), .O_RES(O_RES),
  .O_FLAGS(O_FLAGS), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA), .I_REG_WR(I_REG_WR),
  .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA));

// *** tb/msd_decode_model.sv ***
// Purpose: decode and register-file stand-in that feeds requests to the datapath
// Assumes: one request at a time, driven right after a rising edge
// Notes: operands are inverted once released so stale values never look valid
`timescale 1ns/1ns
module msd_decode_model (
  input wire logic i_clk,
  output msd_pkg::msd_req_s o_req
);
  initial begin
    o_req = '0;
  end
  task automatic issue(input msd_pkg::msd_req_s r);
    @(posedge i_clk);
    o_req <= r;
    @(posedge i_clk);
    // valid drops; everything else flips to expose sampling of dead operands
    o_req <= {1'b0, ~r[$bits(r)-2:0]};
  endtask : issue
endmodule : msd_decode_model

// *** tb/test_multiply_subtract_datapath.sv ***
// Purpose: directed self-checking bench for the multiply-subtract datapath
// Assumes: flag argument of go is {shift1, sat, wide, use_imm}
// Notes: expectations are worked by hand from the operand values
`timescale 1ns/1ns
`define CHK(nm, e, s) begin \
  check_count++; \
  if ((s) !== (e)) begin \
    miscompares++; \
    $display("[FAIL] %s exp %h got %h", nm, e, s); \
  end \
end
module test_multiply_subtract_datapath;
  logic i_clk;
  logic i_rst_n;
  msd_pkg::msd_req_s req;
  msd_pkg::msd_res_s res;
  msd_pkg::msd_flags_s flags;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [8:0] imm;
  int miscompares;
  int check_count;
  msd_pkg::msd_pair_e prs [4] = '{msd_pkg::MSD_PAIR_UU_LL, msd_pkg::MSD_PAIR_UL_LU, msd_pkg::MSD_PAIR_UL_LL,
    msd_pkg::MSD_PAIR_LU_UU};
  logic [63:0] ad_exp [4] = '{64'h0000_00f6_0000_0115, 64'h0000_00f2_0000_010f, 64'h0000_00f2_0000_0115,
    64'h0000_00f1_0000_010a};
  msd_decode_model u_dec (.i_clk(i_clk), .o_req(req));
  msd_datapath u_dut (.I_CLK(i_clk), .I_RST_N(i_rst_n), .I_REQ(req), .O_RES(res), .O_FLAGS(flags),
    .I_REG_ADDR(reg_addr), .I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd), .O_REG_RDATA(reg_rdata));
  always #2 i_clk = ~i_clk;
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge i_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge i_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK("read data", e, reg_rdata)
  endtask : rd
  task automatic go(input msd_pkg::msd_op_e op, input msd_pkg::msd_qsel_e qs, input msd_pkg::msd_pair_e pr,
    input logic [3:0] f, input logic [31:0] a, input logic [31:0] b, input logic [63:0] acc, input logic [63:0] e);
    msd_pkg::msd_req_s r;
    logic ew;
    r = '{1'b1, op, qs, pr, f[3], f[2], f[1], f[0], imm, a, b, acc};
    // packed pairs always fill both words; rounded forms fill one word
    ew = (op inside {msd_pkg::MSD_OP_H, msd_pkg::MSD_OP_AD, msd_pkg::MSD_OP_ADM, msd_pkg::MSD_OP_M}) ||
      (f[1] && !(op inside {msd_pkg::MSD_OP_ADR, msd_pkg::MSD_OP_R}));
    u_dec.issue(r);
    #1;
    `CHK("result valid", 1'b1, res.valid)
    `CHK("result wide", ew, res.wide)
    `CHK("result", e, res.value)
  endtask : go
  initial begin
    #40000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    i_clk = 1'b0;
    i_rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    imm = 9'h1ff;
    repeat (20) @(posedge i_clk);
    i_rst_n <= 1'b1;
    rd(msd_pkg::MSD_ADDR_CTRL, msd_pkg::MSD_CTRL_RST);
    rd(msd_pkg::MSD_ADDR_STAT, 32'h0);
    rd(4'h8, 32'h0);
    go(msd_pkg::MSD_OP_Q, msd_pkg::MSD_Q_WW, prs[0], 4'b1000, 32'h4000_0000, 32'h4000_0000, 64'h3000_0000,
      64'h1000_0000);
    go(msd_pkg::MSD_OP_Q, msd_pkg::MSD_Q_WU, prs[0], 4'b0000, 32'h0001_0000, 32'h0003_1234, 64'ha, 64'h7);
    go(msd_pkg::MSD_OP_Q, msd_pkg::MSD_Q_WW, prs[0], 4'b0010, 32'hffff_ffff, 32'h2, 64'h1_0000_0000,
      64'h1_0000_0002);
    go(msd_pkg::MSD_OP_Q, msd_pkg::MSD_Q_UU, prs[0], 4'b1010, 32'h0002_1111, 32'h0003_2222, 64'h10_0000,
      64'h4_0000);
    go(msd_pkg::MSD_OP_Q, msd_pkg::MSD_Q_UU, prs[0], 4'b1000, 32'h8000_0000, 32'h8000_0000, 64'h0,
      64'h8000_0001);
    go(msd_pkg::MSD_OP_U, msd_pkg::MSD_Q_WW, prs[0], 4'b0000, 32'h3, 32'h5, 64'h14, 64'h5);
    go(msd_pkg::MSD_OP_U, msd_pkg::MSD_Q_WW, prs[0], 4'b0001, 32'h2, 32'hffff_ffff, 64'h1000, 64'hc02);
    go(msd_pkg::MSD_OP_U, msd_pkg::MSD_Q_WW, prs[0], 4'b0100, 32'h3, 32'h5, 64'ha, 64'h0);
    `CHK("flags", 4'b1101, flags)
    go(msd_pkg::MSD_OP_U, msd_pkg::MSD_Q_WW, prs[0], 4'b0010, 32'hffff_ffff, 32'h2, 64'h10_0000_0000,
      64'he_0000_0002);
    for (int i = 0; i < 4; i++) begin
      go(msd_pkg::MSD_OP_AD, msd_pkg::MSD_Q_WW, prs[i], 4'b0010, 32'h0002_0003, 32'h0005_0007,
        64'h0000_0100_0000_0100, ad_exp[i]);
    end
    `CHK("flags", 4'b0101, flags)
    go(msd_pkg::MSD_OP_AD, msd_pkg::MSD_Q_WW, prs[0], 4'b0110, 32'h7fff_0001, 32'h8000_0001,
      64'h7fff_ffff_0000_0005, 64'h7fff_ffff_0000_0006);
    `CHK("flags", 4'b1111, flags)
    wr(msd_pkg::MSD_ADDR_STAT, 32'ha);
    rd(msd_pkg::MSD_ADDR_STAT, 32'h5);
    // flag gating: the result must still come out
    wr(msd_pkg::MSD_ADDR_CTRL, 32'h0);
    go(msd_pkg::MSD_OP_U, msd_pkg::MSD_Q_WW, prs[0], 4'b0100, 32'h3, 32'h5, 64'ha, 64'h0);
    `CHK("flags", 4'b1010, flags)
    wr(msd_pkg::MSD_ADDR_CTRL, 32'h1);
    go(msd_pkg::MSD_OP_ADM, msd_pkg::MSD_Q_WW, prs[0], 4'b0010, 32'h0002_0003, 32'h0005_0007, 64'h100_0000,
      64'h114_fff6);
    go(msd_pkg::MSD_OP_M, msd_pkg::MSD_Q_WW, prs[0], 4'b0010, 32'h0002_0003, 32'h0005_0007, 64'h100_0000,
      64'hea_fff6);
    go(msd_pkg::MSD_OP_ADR, msd_pkg::MSD_Q_WW, prs[0], 4'b1000, 32'h4000_4000, 32'h0001_0003, 64'h0100_0200,
      64'h0100_0202);
    go(msd_pkg::MSD_OP_ADR, msd_pkg::MSD_Q_WW, prs[0], 4'b1010, 32'h4000_4000, 32'h0001_0003,
      64'h0100_0000_0200_0000, 64'h0100_0202);
    go(msd_pkg::MSD_OP_R, msd_pkg::MSD_Q_WW, prs[0], 4'b1000, 32'h4000_4000, 32'h0001_0003, 64'h0100_0200,
      64'h0100_01ff);
    go(msd_pkg::MSD_OP_H, msd_pkg::MSD_Q_WW, prs[0], 4'b0010, 32'h0002_0003, 32'h0005_0007,
      64'h0000_0100_0000_0100, 64'h0000_00f6_0000_00eb);
    go(msd_pkg::MSD_OP_Q, msd_pkg::MSD_Q_WL, prs[0], 4'b0010, 32'hffff_ffff, 32'h0003_0002, 64'h1_0000_0000,
      64'h1_0000_0002);
    go(msd_pkg::MSD_OP_Q, msd_pkg::MSD_Q_LL, prs[0], 4'b1000, 32'h0000_8000, 32'h0000_8000, 64'h0,
      64'h8000_0001);
    tally_and_finish();
  end
endmodule : test_multiply_subtract_datapath

// *** verilog/msd_datapath.sv ***
// Purpose: multiply-subtract datapath, one result per request, one cycle latency
// Assumes: decode presents operands and controls in one cycle with valid high
// Notes: flags and result are registered; exact math in 72 bits, then clamp
//
// Functional notes
// - fractional shift n is 0 or 1, signed
// - 32x32 to 32 subtracts product bits 63:32
// - 32x16 to 32 subtracts product bits 47:16
// - 64-bit fractional subtracts full or 47:0 product
// - 16x16 to 64 shifts product left sixteen
// - unsigned multiply, subtract, matching result width
// - immediate zero-extended before unsigned multiply
// - saturating unsigned clamps to destination range
// - saturating unsigned also for register operands
// - flags from final result, all four updated
// - four halfword operand pairings supported
// - n=1, 0x8000 squared gives 0x7fffffff
// - packed: upper word subtracts, lower adds
// - packed results saturate independently
// - multiprecision: difference, second shifted sixteen
// - multiprecision: sum, second shifted sixteen, subtract
// - rounded packed: subtract upper, add lower, round
// - rounded lower acc halfword placed high first
// - packed 64-bit lower word adds product
// - round adds 0x8000, keeps upper halfword
//
// Implementation choices: the address map and the address-and-strobe port.

`timescale 1ns/1ns

module msd_datapath (
  input wire logic I_CLK,
  input wire logic I_RST_N,
  input wire msd_pkg::msd_req_s I_REQ,
  output msd_pkg::msd_res_s O_RES,
  output msd_pkg::msd_flags_s O_FLAGS,
  input wire logic [3:0] I_REG_ADDR,
  input wire logic [31:0] I_REG_WDATA,
  input wire logic I_REG_WR,
  input wire logic I_REG_RD,
  output logic [31:0] O_REG_RDATA
);

  // signed halfword product with optional left justify
  function automatic logic [31:0] hmul(input logic [15:0] a, input logic [15:0] b, input logic n);
    logic signed [31:0] p;
    p = 32'($signed(a)) * 32'($signed(b));
    if (n && a == msd_pkg::MSD_HW_MIN && b == msd_pkg::MSD_HW_MIN) begin
      hmul = msd_pkg::MSD_Q_MAXPOS;
    end else if (n) begin
      hmul = {p[30:0], 1'b0};
    end else begin
      hmul = p;
    end
  endfunction : hmul

  // range check and clamp of an exact result
  function automatic msd_pkg::msd_chk_s chk(input logic signed [71:0] v, input logic wide, input logic sat,
                                            input logic uns);
    msd_pkg::msd_chk_s c;
    logic signed [71:0] hi_lim;
    logic signed [71:0] lo_lim;
    logic over;
    logic under;
    if (uns) begin
      hi_lim = wide ? msd_pkg::MSD_U64_MAX : msd_pkg::MSD_U32_MAX;
      lo_lim = msd_pkg::MSD_ZERO;
    end else begin
      hi_lim = wide ? msd_pkg::MSD_S64_MAX : msd_pkg::MSD_S32_MAX;
      lo_lim = wide ? msd_pkg::MSD_S64_MIN : msd_pkg::MSD_S32_MIN;
    end
    over = v > hi_lim;
    under = v < lo_lim;
    c.ovf = over | under;
    if (sat && under) begin
      c.val = lo_lim[63:0];
    end else if (sat && over) begin
      c.val = hi_lim[63:0];
    end else begin
      c.val = v[63:0];
    end
    if (!wide) begin
      c.val = {32'h0000_0000, c.val[31:0]};
    end
    // advanced overflow looks at the value actually written
    c.adv = wide ? (c.val[63] ^ c.val[62]) : (c.val[31] ^ c.val[30]);
    return c;
  endfunction : chk

  logic [31:0] ctrl_q;
  logic [31:0] rdata_q;
  msd_pkg::msd_res_s res_q;
  msd_pkg::msd_res_s res_d;
  msd_pkg::msd_flags_s flags_q;
  logic ovf_d;
  logic adv_d;

  logic [31:0] opb_eff;
  logic [15:0] a_hi;
  logic [15:0] a_lo;
  logic [15:0] b_hi;
  logic [15:0] b_lo;
  logic [31:0] p_hi;
  logic [31:0] p_lo;
  logic signed [63:0] p64;
  logic signed [63:0] p64s;
  logic [15:0] b_q16;
  logic signed [47:0] p48;
  logic signed [47:0] p48s;
  logic [31:0] p16;
  logic [63:0] p_uns;

  // the immediate only feeds the unsigned forms
  assign opb_eff = I_REQ.use_imm ? {23'h000000, I_REQ.nine_bit_immediate} : I_REQ.opb;
  assign a_hi = I_REQ.opa[31:16];
  assign a_lo = I_REQ.opa[15:0];
  assign b_hi = I_REQ.opb[31:16];
  assign b_lo = I_REQ.opb[15:0];

  // halfword pairings for the packed and multiprecision forms
  always_comb begin
    case (I_REQ.pair)
      msd_pkg::MSD_PAIR_UU_LL: begin
        p_hi = hmul(a_hi, b_hi, I_REQ.shift1);
        p_lo = hmul(a_lo, b_lo, I_REQ.shift1);
      end
      msd_pkg::MSD_PAIR_UL_LU: begin
        p_hi = hmul(a_hi, b_lo, I_REQ.shift1);
        p_lo = hmul(a_lo, b_hi, I_REQ.shift1);
      end
      msd_pkg::MSD_PAIR_UL_LL: begin
        p_hi = hmul(a_hi, b_lo, I_REQ.shift1);
        p_lo = hmul(a_lo, b_lo, I_REQ.shift1);
      end
      msd_pkg::MSD_PAIR_LU_UU: begin
        p_hi = hmul(a_lo, b_hi, I_REQ.shift1);
        p_lo = hmul(a_hi, b_hi, I_REQ.shift1);
      end
      default: begin
        p_hi = 32'h0000_0000;
        p_lo = 32'h0000_0000;
      end
    endcase
  end

  // fractional products; top bit lost by the shift is intended wrap
  assign p64 = 64'($signed(I_REQ.opa)) * 64'($signed(I_REQ.opb));
  assign p64s = I_REQ.shift1 ? (p64 <<< 1) : p64;
  assign b_q16 = (I_REQ.qsel == msd_pkg::MSD_Q_WU) ? b_hi : b_lo;
  assign p48 = 48'($signed(I_REQ.opa)) * 48'($signed(b_q16));
  assign p48s = I_REQ.shift1 ? (p48 <<< 1) : p48;
  assign p16 = (I_REQ.qsel == msd_pkg::MSD_Q_UU) ? hmul(a_hi, b_hi, I_REQ.shift1) : hmul(a_lo, b_lo, I_REQ.shift1);
  assign p_uns = 64'(I_REQ.opa) * 64'(opb_eff);

  always_comb begin
    logic signed [71:0] accx;
    logic signed [71:0] sub;
    logic signed [71:0] v_hi;
    logic signed [71:0] v_lo;
    logic signed [71:0] acc_hw_hi;
    logic signed [71:0] acc_hw_lo;
    msd_pkg::msd_chk_s c_hi;
    msd_pkg::msd_chk_s c_lo;
    accx = '0;
    sub = '0;
    v_hi = '0;
    v_lo = '0;
    acc_hw_hi = '0;
    acc_hw_lo = '0;
    c_hi = '0;
    c_lo = '0;
    res_d.valid = I_REQ.valid;
    res_d.wide = I_REQ.wide;
    res_d.value = 64'h0000_0000_0000_0000;
    ovf_d = 1'b0;
    adv_d = 1'b0;
    case (I_REQ.op)
      msd_pkg::MSD_OP_Q: begin
        accx = I_REQ.wide ? 72'($signed(I_REQ.acc)) : 72'($signed(I_REQ.acc[31:0]));
        case (I_REQ.qsel)
          msd_pkg::MSD_Q_WW: begin
            sub = I_REQ.wide ? 72'(p64s) : 72'($signed(p64s[63:32]));
          end
          msd_pkg::MSD_Q_WU, msd_pkg::MSD_Q_WL: begin
            sub = I_REQ.wide ? 72'(p48s) : 72'($signed(p48s[47:16]));
          end
          msd_pkg::MSD_Q_UU, msd_pkg::MSD_Q_LL: begin
            if (I_REQ.wide) begin
              sub = 72'($signed(p16)) <<< msd_pkg::MSD_HW_SHIFT;
            end else begin
              sub = 72'($signed(p16));
            end
          end
          default: begin
            sub = '0;
          end
        endcase
        c_hi = chk(accx - sub, I_REQ.wide, I_REQ.sat, 1'b0);
        res_d.value = c_hi.val;
        ovf_d = c_hi.ovf;
        adv_d = c_hi.adv;
      end
      msd_pkg::MSD_OP_U: begin
        // exact unsigned difference; negative means underflow, clamped to zero only with sat
        if (I_REQ.wide) begin
          accx = {8'h00, I_REQ.acc};
        end else begin
          accx = {40'h00_0000_0000, I_REQ.acc[31:0]};
        end
        v_hi = accx - $signed({8'h00, p_uns});
        c_hi = chk(v_hi, I_REQ.wide, I_REQ.sat, 1'b1);
        res_d.value = c_hi.val;
        ovf_d = c_hi.ovf;
        adv_d = c_hi.adv;
      end
      msd_pkg::MSD_OP_H, msd_pkg::MSD_OP_AD: begin
        res_d.wide = 1'b1;
        v_hi = 72'($signed(I_REQ.acc[63:32])) - 72'($signed(p_hi));
        if (I_REQ.op == msd_pkg::MSD_OP_AD) begin
          v_lo = 72'($signed(I_REQ.acc[31:0])) + 72'($signed(p_lo));
        end else begin
          v_lo = 72'($signed(I_REQ.acc[31:0])) - 72'($signed(p_lo));
        end
        c_hi = chk(v_hi, 1'b0, I_REQ.sat, 1'b0);
        c_lo = chk(v_lo, 1'b0, I_REQ.sat, 1'b0);
        res_d.value = {c_hi.val[31:0], c_lo.val[31:0]};
        ovf_d = c_hi.ovf | c_lo.ovf;
        adv_d = c_hi.adv | c_lo.adv;
      end
      msd_pkg::MSD_OP_ADM, msd_pkg::MSD_OP_M: begin
        res_d.wide = 1'b1;
        if (I_REQ.op == msd_pkg::MSD_OP_ADM) begin
          sub = 72'($signed(p_hi)) - (72'($signed(p_lo)) <<< msd_pkg::MSD_HW_SHIFT);
        end else begin
          sub = 72'($signed(p_hi)) + (72'($signed(p_lo)) <<< msd_pkg::MSD_HW_SHIFT);
        end
        c_hi = chk(72'($signed(I_REQ.acc)) - sub, 1'b1, I_REQ.sat, 1'b0);
        res_d.value = c_hi.val;
        ovf_d = c_hi.ovf;
        adv_d = c_hi.adv;
      end
      msd_pkg::MSD_OP_ADR, msd_pkg::MSD_OP_R: begin
        res_d.wide = 1'b0;
        // wide selects the 64-bit accumulator special case
        if (I_REQ.wide) begin
          acc_hw_hi = 72'($signed(I_REQ.acc[63:32]));
          acc_hw_lo = 72'($signed(I_REQ.acc[31:0]));
        end else begin
          acc_hw_hi = 72'($signed({I_REQ.acc[31:16], 16'h0000}));
          acc_hw_lo = 72'($signed({I_REQ.acc[15:0], 16'h0000}));
        end
        v_hi = acc_hw_hi - 72'($signed(p_hi)) + msd_pkg::MSD_RND_BIAS;
        if (I_REQ.op == msd_pkg::MSD_OP_ADR) begin
          v_lo = acc_hw_lo + 72'($signed(p_lo)) + msd_pkg::MSD_RND_BIAS;
        end else begin
          v_lo = acc_hw_lo - 72'($signed(p_lo)) + msd_pkg::MSD_RND_BIAS;
        end
        c_hi = chk(v_hi, 1'b0, I_REQ.sat, 1'b0);
        c_lo = chk(v_lo, 1'b0, I_REQ.sat, 1'b0);
        // halfword_round: low sixteen bits dropped after the bias
        res_d.value = {32'h0000_0000, c_hi.val[31:16], c_lo.val[31:16]};
        ovf_d = c_hi.ovf | c_lo.ovf;
        adv_d = c_hi.adv | c_lo.adv;
      end
      default: begin
        res_d.valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      res_q <= '0;
    end else begin
      res_q <= res_d;
    end
  end

  logic flag_upd;
  logic clr_sticky_ovf;
  logic clr_sticky_adv;
  logic ovf_q;
  logic adv_ovf_q;
  logic sticky_ovf_q;
  logic sticky_adv_q;

  // flags take instruction results only on a valid instruction while updates are enabled; sticky clears by status write are not gated
  assign flag_upd = res_d.valid && ctrl_q[msd_pkg::MSD_CTRL_FLAG_EN];
  // writing one to a sticky bit of the status word clears it
  assign clr_sticky_ovf = I_REG_WR && (I_REG_ADDR == msd_pkg::MSD_ADDR_STAT) &&
                          I_REG_WDATA[msd_pkg::MSD_ST_STICKY_OVF];
  assign clr_sticky_adv = I_REG_WR && (I_REG_ADDR == msd_pkg::MSD_ADDR_STAT) &&
                          I_REG_WDATA[msd_pkg::MSD_ST_STICKY_ADV_OVF];

  // plain flags describe the latest enabled instruction only
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ovf_q <= 1'b0;
    end else if (flag_upd) begin
      ovf_q <= ovf_d;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      adv_ovf_q <= 1'b0;
    end else if (flag_upd) begin
      adv_ovf_q <= adv_d;
    end
  end

  // a set in the same cycle as a software clear wins, so no event is lost
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      sticky_ovf_q <= 1'b0;
    end else if (flag_upd && ovf_d) begin
      sticky_ovf_q <= 1'b1;
    end else if (clr_sticky_ovf) begin
      sticky_ovf_q <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      sticky_adv_q <= 1'b0;
    end else if (flag_upd && adv_d) begin
      sticky_adv_q <= 1'b1;
    end else if (clr_sticky_adv) begin
      sticky_adv_q <= 1'b0;
    end
  end

  // gathered for the status read and the flag port; every bit is a flop
  assign flags_q = '{ovf: ovf_q, sticky_ovf_flag: sticky_ovf_q, adv_ovf_flag: adv_ovf_q,
                     sticky_adv_ovf_flag: sticky_adv_q};

  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ctrl_q <= msd_pkg::MSD_CTRL_RST;
    end else if (I_REG_WR && I_REG_ADDR == msd_pkg::MSD_ADDR_CTRL) begin
      ctrl_q <= {31'h0000_0000, I_REG_WDATA[msd_pkg::MSD_CTRL_FLAG_EN]};
    end
  end

  // read data valid only in the cycle after the strobe; unmapped reads zero
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rdata_q <= 32'h0000_0000;
    end else if (I_REG_RD && I_REG_ADDR == msd_pkg::MSD_ADDR_CTRL) begin
      rdata_q <= ctrl_q;
    end else if (I_REG_RD && I_REG_ADDR == msd_pkg::MSD_ADDR_STAT) begin
      rdata_q <= {28'h000_0000, flags_q.sticky_adv_ovf_flag, flags_q.adv_ovf_flag,
                  flags_q.sticky_ovf_flag, flags_q.ovf};
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign O_RES = res_q;
  assign O_FLAGS = flags_q;
  assign O_REG_RDATA = rdata_q;

endmodule : msd_datapath

// *** verilog/msd_pkg.sv ***
// Purpose: shared constants and carrier types for the multiply-subtract datapath
// Assumes: one 250 MHz core clock, single-cycle operand delivery from decode
// Notes: opcodes and operand selects are one-hot

package msd_pkg;

  // register port map
  localparam logic [3:0] MSD_ADDR_CTRL = 4'h0;
  localparam logic [3:0] MSD_ADDR_STAT = 4'h4;
  localparam logic [31:0] MSD_CTRL_RST = 32'h0000_0001;
  localparam int MSD_CTRL_FLAG_EN = 0;
  localparam int MSD_ST_OVF = 0;
  localparam int MSD_ST_STICKY_OVF = 1;
  localparam int MSD_ST_ADV_OVF = 2;
  localparam int MSD_ST_STICKY_ADV_OVF = 3;

  // arithmetic constants
  localparam logic [15:0] MSD_HW_MIN = 16'h8000;
  localparam logic [31:0] MSD_Q_MAXPOS = 32'h7fff_ffff;
  localparam logic signed [71:0] MSD_RND_BIAS = 72'sh00_0000_0000_0000_8000;
  localparam int MSD_HW_SHIFT = 16;
  localparam logic signed [71:0] MSD_S32_MAX = 72'sh00_0000_0000_7fff_ffff;
  localparam logic signed [71:0] MSD_S32_MIN = 72'shff_ffff_ffff_8000_0000;
  localparam logic signed [71:0] MSD_S64_MAX = 72'sh00_7fff_ffff_ffff_ffff;
  localparam logic signed [71:0] MSD_S64_MIN = 72'shff_8000_0000_0000_0000;
  localparam logic signed [71:0] MSD_U32_MAX = 72'sh00_0000_0000_ffff_ffff;
  localparam logic signed [71:0] MSD_U64_MAX = 72'sh00_ffff_ffff_ffff_ffff;
  localparam logic signed [71:0] MSD_ZERO = 72'sh00_0000_0000_0000_0000;

  typedef enum logic [7:0] {
    MSD_OP_Q   = 8'h01, // fractional
    MSD_OP_U   = 8'h02, // unsigned
    MSD_OP_H   = 8'h04, // packed sub/sub
    MSD_OP_AD  = 8'h08, // packed_mul_sub_add
    MSD_OP_ADM = 8'h10, // multiprecision sub/add
    MSD_OP_M   = 8'h20, // multiprecision sub
    MSD_OP_ADR = 8'h40, // packed_mul_sub_add_rounded
    MSD_OP_R   = 8'h80  // packed sub/sub rounded
  } msd_op_e;

  typedef enum logic [4:0] {
    MSD_Q_WW = 5'h01,
    MSD_Q_WU = 5'h02,
    MSD_Q_WL = 5'h04,
    MSD_Q_UU = 5'h08,
    MSD_Q_LL = 5'h10
  } msd_qsel_e;

  typedef enum logic [3:0] {
    MSD_PAIR_UU_LL = 4'h1,
    MSD_PAIR_UL_LU = 4'h2,
    MSD_PAIR_UL_LL = 4'h4,
    MSD_PAIR_LU_UU = 4'h8
  } msd_pair_e;

  typedef struct packed {
    logic valid;
    msd_op_e op;
    msd_qsel_e qsel;
    msd_pair_e pair;
    logic shift1;
    logic sat;
    logic wide;
    logic use_imm;
    logic [8:0] nine_bit_immediate;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [63:0] acc;
  } msd_req_s;

  typedef struct packed {
    logic valid;
    logic wide;
    logic [63:0] value;
  } msd_res_s;

  typedef struct packed {
    logic ovf;
    logic sticky_ovf_flag;
    logic adv_ovf_flag;
    logic sticky_adv_ovf_flag;
  } msd_flags_s;

  typedef struct packed {
    logic [63:0] val;
    logic ovf;
    logic adv;
  } msd_chk_s;

endpackage : msd_pkg
